// ===== hdl/dcf_fifo_ctrl.sv
// Fifo control: pointers, flags, timing modes and offset registers
`timescale 1ns/1ns
`include "dcf_cfg.svh"
module dcf_fifo_ctrl #(
   parameter int DEPTH = 512,
   // Codes on {first_device_n, read_chain_in_n, write_chain_in_n}
   parameter logic [2:0] SEL_STD_SYNC = 3'h0,
   parameter logic [2:0] SEL_STD_ASYNC = 3'h1,
   parameter logic [2:0] SEL_FIRST_WORD_FALLTHROUGH_SYNC = 3'h2,
   parameter logic [2:0] SEL_FIRST_WORD_FALLTHROUGH_ASYNC = 3'h3
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic fifo_reset_n_in,
   input wire logic write_enable_n_in,
   input wire logic read_enable_n_in,
   input wire logic offset_load_n_in,
   input wire logic output_enable_n_in,
   input wire logic first_device_n_in,
   input wire logic read_chain_in_n_in,
   input wire logic write_chain_in_n_in,
   input wire dcf_pkg::dcf_word_t data_in,
   output dcf_pkg::dcf_word_t data_out,
   output logic data_oe_out,
   output dcf_pkg::dcf_flags_t flags_out
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 2;
   localparam logic [CW-1:0] CAP_STD = CW'(DEPTH);
   localparam logic [CW-1:0] CAP_FIRST_WORD_FALLTHROUGH = CW'(DEPTH + 1);
   localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);
   // Smaller part gets the smaller default offset
   localparam dcf_pkg::dcf_off_t OFF_DEF = (DEPTH == `DCF_SMALL_DEPTH) ?
      `DCF_OFF_DEF_SMALL : `DCF_OFF_DEF_LARGE;

   dcf_pkg::dcf_word_t mem [DEPTH]; // Main storage
   logic [AW:0] wr_ptr_q; // Write pointer with wrap bit
   logic [AW:0] rd_ptr_q; // Read pointer with wrap bit
   logic [AW:0] wr_seen_q; // Read side's delayed view of wr_ptr
   logic [CW-1:0] occ_q; // Words held, output register included
   logic [CW-1:0] occ_d;
   logic first_word_fallthrough_q; // Fall-through timing chosen
   logic async_q; // Combinational almost flags chosen
   logic full_q; // Internal full, positive sense
   logic out_valid_q; // Fall-through output register holds a word
   dcf_pkg::dcf_word_t data_q; // Output register
   dcf_pkg::dcf_off_t off_q [2]; // Empty and full offsets
   dcf_pkg::dcf_sel_t wsel_q; // Offset write sequence pointer
   dcf_pkg::dcf_sel_t rsel_q; // Offset read sequence pointer
   dcf_pkg::dcf_flags_t flags_q; // Registered pin flags
   logic hf_d;
   logic af_d;
   logic ae_d;
   logic [2:0] mode_sel;
   logic buf_in_ready;
   logic buf_valid;
   logic mem_room;
   dcf_pkg::dcf_word_t buf_data;
   logic accept; // Word taken from data_in
   logic drain; // Word moved from buffer to memory
   logic mem_avail; // Memory holds a word the read side sees
   logic std_rd; // Standard mode data read
   logic first_word_fallthrough_load; // Fall-through load of output register
   logic true_rd; // Fall-through read of a valid output word
   logic dec; // A word leaves the device
   logic off_wr;
   logic off_rd;
   logic [CW-1:0] cap;

   assign mode_sel = {first_device_n_in, read_chain_in_n_in,
      write_chain_in_n_in};
   assign cap = first_word_fallthrough_q ? CAP_FIRST_WORD_FALLTHROUGH : CAP_STD;
   // Writes gated by enable, load pin and the full flag
   assign accept = fifo_reset_n_in && offset_load_n_in &&
      !write_enable_n_in && !full_q && buf_in_ready;
   assign off_wr = fifo_reset_n_in && !offset_load_n_in &&
      !write_enable_n_in;
   assign off_rd = fifo_reset_n_in && !offset_load_n_in &&
      !read_enable_n_in && !first_word_fallthrough_q;
   assign mem_room = (wr_ptr_q - rd_ptr_q) != (AW + 1)'(DEPTH);
   assign drain = fifo_reset_n_in && buf_valid && mem_room;
   assign mem_avail = (wr_seen_q != rd_ptr_q);
   assign std_rd = fifo_reset_n_in && !first_word_fallthrough_q && offset_load_n_in &&
      !read_enable_n_in && flags_q.empty_or;
   assign true_rd = fifo_reset_n_in && first_word_fallthrough_q && offset_load_n_in &&
      !read_enable_n_in && out_valid_q;
   assign first_word_fallthrough_load = fifo_reset_n_in && first_word_fallthrough_q && mem_avail &&
      (!out_valid_q || true_rd);
   assign dec = std_rd || true_rd;
   assign occ_d = occ_q + CW'(accept) - CW'(dec);

   // Incoming words wait here until the array has room; a stalled
   // drain pushes back through buf_in_ready into accept
   dcf_skid_buf #(.W(`DCF_DATA_W)) u_in_buf (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .clear_in(!fifo_reset_n_in),
      .in_valid_in(accept),
      .in_ready_out(buf_in_ready),
      .in_data_in(data_in),
      .out_valid_out(buf_valid),
      .out_ready_in(mem_room),
      .out_data_out(buf_data)
   );

   // Mode straps caught while the fifo reset pin is low
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         first_word_fallthrough_q <= 1'b0;
         async_q <= 1'b0;
      end else if (!fifo_reset_n_in) begin
         first_word_fallthrough_q <= (mode_sel == SEL_FIRST_WORD_FALLTHROUGH_SYNC) ||
            (mode_sel == SEL_FIRST_WORD_FALLTHROUGH_ASYNC);
         async_q <= (mode_sel == SEL_STD_ASYNC) ||
            (mode_sel == SEL_FIRST_WORD_FALLTHROUGH_ASYNC);
      end
   end

   // Array write; no reset needed for storage
   always_ff @(posedge sys_clk_in) begin
      if (drain) begin
         mem[wr_ptr_q[AW-1:0]] <= buf_data;
      end
   end

   // Pointers and the delayed write view
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         wr_seen_q <= '0;
      end else if (!fifo_reset_n_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         wr_seen_q <= '0;
      end else begin
         if (drain) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (std_rd || first_word_fallthrough_load) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         // Extra stage puts the first fall-through word on edge three
         wr_seen_q <= wr_ptr_q;
      end
   end

   // Occupancy and internal full
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         occ_q <= '0;
         full_q <= 1'b0;
      end else if (!fifo_reset_n_in) begin
         occ_q <= '0;
         full_q <= 1'b0;
      end else begin
         occ_q <= occ_d;
         full_q <= (occ_d == cap);
      end
   end

   // Output register: data, offset readback, or hold
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         data_q <= `DCF_WORD_ZERO;
         out_valid_q <= 1'b0;
      end else if (!fifo_reset_n_in) begin
         data_q <= `DCF_WORD_ZERO;
         out_valid_q <= 1'b0;
      end else if (off_rd) begin
         data_q <= dcf_pkg::dcf_word_t'(off_q[rsel_q]);
      end else if (std_rd || first_word_fallthrough_load) begin
         data_q <= mem[rd_ptr_q[AW-1:0]];
         out_valid_q <= first_word_fallthrough_q;
      end else if (true_rd) begin
         // Last word stays on the pins, reads now inhibited
         out_valid_q <= 1'b0;
      end
   end

   // Offset registers and their two sequence pointers
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         off_q[0] <= OFF_DEF;
         off_q[1] <= OFF_DEF;
         wsel_q <= dcf_pkg::DCF_SEL_EMPTY;
         rsel_q <= dcf_pkg::DCF_SEL_EMPTY;
      end else if (!fifo_reset_n_in) begin
         off_q[0] <= OFF_DEF;
         off_q[1] <= OFF_DEF;
         wsel_q <= dcf_pkg::DCF_SEL_EMPTY;
         rsel_q <= dcf_pkg::DCF_SEL_EMPTY;
      end else begin
         // Pointer survives load going high, so loading resumes
         if (off_wr) begin
            off_q[wsel_q] <= data_in[`DCF_OFF_W-1:0];
            wsel_q <= dcf_pkg::dcf_sel_t'(~wsel_q);
         end
         if (off_rd) begin
            rsel_q <= dcf_pkg::dcf_sel_t'(~rsel_q);
         end
      end
   end

   // Almost and half conditions from occupancy
   always_comb begin
      hf_d = (occ_d > HALF);
      af_d = (occ_d >= cap - CW'(off_q[1]));
      ae_d = (occ_d <= CW'(off_q[0]) + CW'(first_word_fallthrough_q));
   end

   // Pin flags; full and empty track the timing mode's polarity
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         flags_q <= '{full_ir: 1'b1, empty_or: 1'b0, half_full_n: 1'b1,
            almost_full_n: 1'b1, almost_empty_n: 1'b1};
      end else if (!fifo_reset_n_in) begin
         flags_q.full_ir <= !first_word_fallthrough_q;
         flags_q.empty_or <= first_word_fallthrough_q;
         flags_q.half_full_n <= 1'b1;
         flags_q.almost_full_n <= 1'b1;
         flags_q.almost_empty_n <= 1'b1;
      end else begin
         flags_q.full_ir <= first_word_fallthrough_q ? (occ_d == cap) :
            (occ_d != cap);
         flags_q.empty_or <= first_word_fallthrough_q ? !(first_word_fallthrough_load || (out_valid_q &&
            !true_rd)) : ((rd_ptr_q + (AW + 1)'(std_rd)) != wr_ptr_q);
         flags_q.half_full_n <= !hf_d;
         flags_q.almost_full_n <= !af_d;
         flags_q.almost_empty_n <= !ae_d;
      end
   end

   // Output pins; async flag mode bypasses the almost-flag stage
   always_comb begin
      flags_out = flags_q;
      if (async_q && fifo_reset_n_in) begin
         flags_out.almost_full_n = !(occ_q >= cap - CW'(off_q[1]));
         flags_out.almost_empty_n = !(occ_q <= CW'(off_q[0]) +
            CW'(first_word_fallthrough_q));
      end
   end
   assign data_out = data_q;
   assign data_oe_out = !output_enable_n_in;

   default clocking dcf_cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   // First fall-through word: write into an idle fifo, then edges
   sequence first_write_s;
      first_word_fallthrough_q && occ_q == '0 && accept && !out_valid_q;
   endsequence
   sequence quiet_s;
      fifo_reset_n_in;
   endsequence

   reset_ptrs_a: assert property (!fifo_reset_n_in |=>
      wr_ptr_q == '0 && rd_ptr_q == '0)
      else $error("pointers not home after fifo reset");
   reset_flags_a: assert property (!fifo_reset_n_in |=>
      flags_q.half_full_n && flags_q.almost_full_n &&
      flags_q.almost_empty_n)
      else $error("half or almost flags low after reset");
   // Flag follows the mode as it stood at the reset edge itself
   reset_empty_a: assert property (!fifo_reset_n_in &&
      $stable(first_word_fallthrough_q) |=> flags_q.empty_or == $past(first_word_fallthrough_q))
      else $error("empty pin wrong level after reset");
   reset_out_a: assert property (!fifo_reset_n_in |=>
      data_q == `DCF_WORD_ZERO && off_q[0] == OFF_DEF &&
      off_q[1] == OFF_DEF)
      else $error("output or offsets not cleared by reset");
   // Judged from the pin flag, not from the gate's own terms
   write_gate_a: assert property ((flags_q.full_ir == first_word_fallthrough_q) ||
      write_enable_n_in || !offset_load_n_in |-> !accept)
      else $error("word taken while disabled or full");
   occ_step_a: assert property (accept && !dec |=>
      occ_q == $past(occ_q) + 1'b1)
      else $error("accepted word not counted");
   full_match_a: assert property (fifo_reset_n_in &&
      $past(fifo_reset_n_in) |-> full_q == (occ_q == cap))
      else $error("full flag disagrees with depth");
   read_hold_a: assert property (fifo_reset_n_in && read_enable_n_in &&
      !first_word_fallthrough_q |=> $stable(data_q))
      else $error("output changed without a read");
   first_word_fallthrough_first_a: assert property (first_write_s ##1 quiet_s[*3] |->
      !out_valid_q ##1 out_valid_q)
      else $error("first word not out on third edge");
   or_hold_a: assert property (out_valid_q && !true_rd &&
      fifo_reset_n_in |=> out_valid_q)
      else $error("output ready dropped without true read");
   oe_gate_a: assert property (data_oe_out == !output_enable_n_in)
      else $error("data drive not following output enable");
   off_seq_a: assert property (off_wr |=> wsel_q != $past(wsel_q))
      else $error("offset write pointer did not advance");
   // A word already buffered may still drain, so watch offsets and count
   ld_idle_a: assert property (fifo_reset_n_in && !offset_load_n_in &&
      write_enable_n_in |=> $stable(wsel_q) && $stable(off_q[0]) &&
      $stable(off_q[1]) && occ_q <= $past(occ_q))
      else $error("load with write disabled changed state");
   rb_block_a: assert property (first_word_fallthrough_q && !offset_load_n_in |=>
      $stable(rsel_q))
      else $error("offset readback moved in fall-through");
endmodule

// ===== hdl/dcf_skid_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module dcf_skid_buf #(
   parameter int W = 18
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic clear_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   logic [W-1:0] slot_q [2]; // Entry 0 is the head
   logic [1:0] cnt_q; // Entries held
   logic push;
   logic pop;

   // Handshakes straight from the fill count
   assign in_ready_out = (cnt_q != 2'h2);
   assign out_valid_out = (cnt_q != 2'h0);
   assign out_data_out = slot_q[0];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   // Fill count
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q <= 2'h0;
      end else if (clear_in) begin
         cnt_q <= 2'h0;
      end else begin
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   // Storage; a pop shifts the tail forward so the head stays in slot 0
   always_ff @(posedge sys_clk_in) begin
      if (pop) begin
         slot_q[0] <= slot_q[1];
      end
      if (push) begin
         if (pop) begin
            slot_q[cnt_q == 2'h2 ? 1 : 0] <= in_data_in;
            if (cnt_q == 2'h2) begin
               slot_q[1] <= in_data_in;
            end
         end else begin
            slot_q[cnt_q[0]] <= in_data_in;
         end
      end
   end
endmodule

// ===== shared/dcf_cfg.svh
// Constants shared by the dual-clock fifo control block
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH
`define DCF_DATA_W 18
`define DCF_OFF_W 12
`define DCF_SMALL_DEPTH 512
`define DCF_OFF_DEF_SMALL 12'h03F
`define DCF_OFF_DEF_LARGE 12'h07F
`define DCF_WORD_ZERO 18'h0_0000
`define DCF_CLK_NS 10
`define DCF_RST_TO_FLAG_NS 10
`define DCF_RST_TO_FLAG_CYC ((`DCF_RST_TO_FLAG_NS) / (`DCF_CLK_NS))
`endif

// ===== shared/dcf_pkg.sv
// Types for the fifo control block
`include "dcf_cfg.svh"
package dcf_pkg;
   // One data word
   typedef logic [`DCF_DATA_W-1:0] dcf_word_t;
   // One threshold offset
   typedef logic [`DCF_OFF_W-1:0] dcf_off_t;
   // Which offset register a sequence pointer names
   typedef enum logic {
      DCF_SEL_EMPTY = 1'b0,
      DCF_SEL_FULL = 1'b1
   } dcf_sel_t;
   // Status pins; half and almost flags active low, full and empty active low in standard mode only
   typedef struct packed {
      logic full_ir;
      logic empty_or;
      logic half_full_n;
      logic almost_full_n;
      logic almost_empty_n;
   } dcf_flags_t;
endpackage

// ===== tb/dcf_fifo_ctrl_tb_top.sv
// Bench top: drives the fifo control through the host model
`timescale 1ns/1ns
`include "dcf_cfg.svh"
module dcf_fifo_ctrl_tb_top;
   // Smallest depth keeps fill runs short
   localparam int DEPTH = `DCF_SMALL_DEPTH;
   localparam dcf_pkg::dcf_word_t DEF_OFF = {6'h00, `DCF_OFF_DEF_SMALL};
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic oe_n = 1'b0;
   // Pins from the host model
   logic fifo_reset_n, wr_en_n, rd_en_n, ld_n;
   logic [2:0] strap;
   dcf_pkg::dcf_word_t wr_data;
   // Design outputs
   dcf_pkg::dcf_word_t data_out;
   logic data_oe_out;
   dcf_pkg::dcf_flags_t flags_out;
   int fail_count = 0;
   int n_compared = 0;
   int i;
   // 100 MHz clock
   always #5 sys_clk_in = ~sys_clk_in;
   dcf_fifo_ctrl #(.DEPTH(DEPTH)) dcf_fifo_ctrl_inst (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .fifo_reset_n_in(fifo_reset_n), .write_enable_n_in(wr_en_n),
      .read_enable_n_in(rd_en_n), .offset_load_n_in(ld_n),
      .output_enable_n_in(oe_n), .first_device_n_in(strap[2]),
      .read_chain_in_n_in(strap[1]), .write_chain_in_n_in(strap[0]),
      .data_in(wr_data), .data_out(data_out),
      .data_oe_out(data_oe_out), .flags_out(flags_out));
   dcf_host_model dcf_host_model_inst (
      .sys_clk_in(sys_clk_in), .fifo_reset_n_out(fifo_reset_n),
      .write_enable_n_out(wr_en_n), .read_enable_n_out(rd_en_n),
      .offset_load_n_out(ld_n), .strap_out(strap), .data_out(wr_data));
   // Shared compare
   task automatic check(input dcf_pkg::dcf_word_t seen,
                        input dcf_pkg::dcf_word_t exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t ns: saw %h, wanted %h", $time, seen,
                  exp);
      end
   endtask
   // Widen one flag bit for the shared compare
   function automatic dcf_pkg::dcf_word_t fb(input logic b);
      return {17'h0_0000, b};
   endfunction
   // Counts, verdict, end of run
   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Bounded wait: full_ir when sel is 1, else empty_or
   task automatic wait_flag(input logic sel, input logic want);
      int n;
      for (n = 0; n < 40; n++) begin
         if ((sel ? flags_out.full_ir : flags_out.empty_or) === want) begin
            break;
         end
         @(negedge sys_clk_in);
      end
      if (n == 40) begin
         fail_count++;
         $display("unexpected at %0t ns: flag wait ran out", $time);
         results();
      end
   endtask
   task automatic wr(input dcf_pkg::dcf_word_t d);
      dcf_host_model_inst.access(1'b0, 1'b1, 1'b1, d);
   endtask
   task automatic rd();
      dcf_host_model_inst.access(1'b1, 1'b0, 1'b1, 18'h0_0000);
   endtask
   // Standard read once the word has crossed
   task automatic std_read(input dcf_pkg::dcf_word_t exp);
      wait_flag(1'b0, 1'b1);
      rd();
      check(data_out, exp);
   endtask
   // n writes, no reads; full shows on the n-th only
   task automatic fill(input int n, input logic lvl);
      for (int k = 0; k < n; k++) begin
         wr(dcf_pkg::dcf_word_t'(k));
         if (k >= n - 2) begin
            check(fb(flags_out.full_ir), fb(k == n - 1 ? lvl : ~lvl));
         end
      end
   endtask
   // Main sequence
   initial begin
      repeat (8) @(negedge sys_clk_in);
      rst_in = 1'b0;
      dcf_host_model_inst.fifo_reset(3'h0);
      check({13'h0000, flags_out}, 18'h0_0017);
      check(data_out, 18'h0_0000);
      // Defaults come back empty then full
      repeat (2) begin
         dcf_host_model_inst.offset_read();
         check(data_out, DEF_OFF);
      end
      // One offset, a disabled load cycle, the next, then wrap
      dcf_host_model_inst.offset_write(12'h005);
      dcf_host_model_inst.access(1'b1, 1'b1, 1'b0, 18'h0_0FFF);
      dcf_host_model_inst.offset_write(12'h1A0);
      dcf_host_model_inst.offset_write(12'h009);
      dcf_host_model_inst.offset_read();
      check(data_out, 18'h0_0009);
      dcf_host_model_inst.offset_read();
      check(data_out, 18'h0_01A0);
      // Output enable gates the drive
      @(negedge sys_clk_in);
      oe_n = 1'b1;
      #1 check(fb(data_oe_out), fb(1'b0));
      oe_n = 1'b0;
      #1 check(fb(data_oe_out), fb(1'b1));
      // Standard: no word until read, then in order
      wr(18'h3_0001);
      wr(18'h0_C002);
      wr(18'h1_5003);
      wait_flag(1'b0, 1'b1);
      check(data_out, 18'h0_01A0);
      std_read(18'h3_0001);
      std_read(18'h0_C002);
      std_read(18'h1_5003);
      check(fb(flags_out.empty_or), fb(1'b0));
      rd();
      check(data_out, 18'h1_5003);
      dcf_host_model_inst.access(1'b1, 1'b1, 1'b1, 18'h2_0000);
      repeat (4) @(negedge sys_clk_in);
      check(fb(flags_out.empty_or), fb(1'b0));
      // Fill, refuse one more, drain all
      fill(DEPTH, 1'b0);
      wr(18'h3_FFFF);
      check(fb(flags_out.full_ir), fb(1'b0));
      std_read(18'h0_0000);
      wait_flag(1'b1, 1'b1);
      check(fb(flags_out.full_ir), fb(1'b1));
      for (i = 1; i < DEPTH; i++) begin
         std_read(dcf_pkg::dcf_word_t'(i));
      end
      repeat (4) @(negedge sys_clk_in);
      check(fb(flags_out.empty_or), fb(1'b0));
      // Async flag mode: almost-empty follows the count at once
      dcf_host_model_inst.fifo_reset(3'h1);
      #1 check({13'h0000, flags_out}, 18'h0_0016);
      // Fall-through mode
      dcf_host_model_inst.fifo_reset(3'h2);
      check({13'h0000, flags_out}, 18'h0_000F);
      wr(18'h2_1234);
      repeat (2) @(negedge sys_clk_in);
      check(fb(flags_out.empty_or), fb(1'b1));
      @(negedge sys_clk_in);
      check(fb(flags_out.empty_or), fb(1'b0));
      check(data_out, 18'h2_1234);
      wr(18'h1_0BEE);
      repeat (4) @(negedge sys_clk_in);
      check(data_out, 18'h2_1234);
      dcf_host_model_inst.offset_read();
      check(data_out, 18'h2_1234);
      rd();
      check(data_out, 18'h1_0BEE);
      check(fb(flags_out.empty_or), fb(1'b0));
      rd();
      check(fb(flags_out.empty_or), fb(1'b1));
      check(data_out, 18'h1_0BEE);
      fill(DEPTH + 1, 1'b1);
      results();
   end
endmodule

// ===== tb/dcf_host_model.sv
// Host model: writer and reader that drive the fifo control pins
`timescale 1ns/1ns
module dcf_host_model (
   input wire logic sys_clk_in,
   output logic fifo_reset_n_out,
   output logic write_enable_n_out,
   output logic read_enable_n_out,
   output logic offset_load_n_out,
   output logic [2:0] strap_out,
   output dcf_pkg::dcf_word_t data_out
);
   // Idle at time zero; straps pick standard sync
   initial begin
      fifo_reset_n_out = 1'b1;
      write_enable_n_out = 1'b1;
      read_enable_n_out = 1'b1;
      offset_load_n_out = 1'b1;
      strap_out = 3'h0;
      data_out = 18'h0_0000;
   end
   // Reset low for two edges so the flags see the latched mode
   task automatic fifo_reset(input logic [2:0] mode);
      @(negedge sys_clk_in);
      strap_out = mode;
      fifo_reset_n_out = 1'b0;
      repeat (2) @(negedge sys_clk_in);
      fifo_reset_n_out = 1'b1;
      // Straps move after reset; the latched mode must not follow
      strap_out = ~mode;
   endtask
   // Pins set after a falling edge, taken at the next rising edge,
   // released at the falling edge after that
   task automatic access(input logic we_n, input logic re_n,
                         input logic ld_n, input dcf_pkg::dcf_word_t d);
      @(negedge sys_clk_in);
      write_enable_n_out = we_n;
      read_enable_n_out = re_n;
      offset_load_n_out = ld_n;
      data_out = d;
      @(negedge sys_clk_in);
      write_enable_n_out = 1'b1;
      read_enable_n_out = 1'b1;
      offset_load_n_out = 1'b1;
      // Released bus shows the inverse so stale data never passes
      data_out = ~d;
   endtask
   // Offset write, upper bits zero
   task automatic offset_write(input dcf_pkg::dcf_off_t off);
      access(1'b0, 1'b1, 1'b0, {6'h00, off});
   endtask
   // Offset read alone, never with a write
   task automatic offset_read();
      access(1'b1, 1'b0, 1'b0, 18'h0_0000);
   endtask
endmodule
